/* File: rtl/vim_status.sv */
// Maintenance status flags and virtual machine control view of a virtual CPU interface.
`timescale 1ns/1ps
// What this block does
// - Bit 7 set when group 1 off interrupt enabled and VM group 1 off.
// - Bit 6 set when group 1 on interrupt enabled and VM group 1 on.
// - Bit 5 set when group 0 off interrupt enabled and VM group 0 off.
// - Bit 4 set when group 0 on interrupt enabled and VM group 0 on.
// - Bit 3 set when no-pending enabled and no entry is pending.
// - Bit 2 set when missing-slot enabled and outstanding count nonzero.
// - Bit 1 set when sparse enabled and at most one entry valid.
// - Bit 0 set when any completion status bit is one.
// - Every status flag reads zero out of reset.
// - Only state 01 counts as pending; active-and-pending does not.
// - Mask in bits 31:24; signal only priorities higher than mask.
// - VM writes to its interface fields update the alias fields.
// - Group 0 split point also governs group 1 when shared bit set.
// - Group 1 split point governs group 1 only when shared bit clear.
// - Bit 9 clear: completion drops and deactivates; set: drop only.
// - Bit 4 picks group 1 split source: alias or main register.
// - Bit 3 routes group 0 as IRQ when 0, fast IRQ when 1.
// - With bit 2 clear, group 1 top pending reads return ID 1022.
// - Bits 1 and 0 enable groups 1 and 0 respectively.
// - Read-only type register reports priority bits and entry count.
// - Maintenance output needs a set flag and the global enable.
// - Type bits 4:0 hold entry count minus one.
module vim_status #(
   parameter int NUM_ENTRIES = 4,
   parameter int PRI_BITS = 5,
   parameter int PRE_BITS = 5
) (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic regWr, // Register write strobe.
   input wire logic regRd, // Register read strobe.
   input wire logic [7:0] regAddr, // Byte offset.
   input wire logic [31:0] regWdata, // Write data.
   output logic [31:0] regRdata, // Read data, registered.
   input wire vim_pkg::vim_hyp_t hyp, // Hypervisor enables.
   input wire logic [4:0] outstandingCompletionCount, // Outstanding completion count.
   input wire logic [2*NUM_ENTRIES-1:0] entryState, // Per-entry state fields.
   input wire logic [NUM_ENTRIES-1:0] completionStatus, // Completion status bits.
   input wire vim_pkg::vim_vmwr_t vmWr, // VM alias-field write.
   input wire logic [7:0] topPriority, // Priority of top pending interrupt.
   input wire logic topIsG1, // Top pending interrupt is group 1.
   input wire logic [9:0] topId, // ID of top pending interrupt.
   input wire logic topValid, // A top pending interrupt exists.
   output logic maintIrq, // Maintenance interrupt level.
   output logic [7:0] statusFlags, // Live maintenance flags.
   output logic [9:0] vmAckId, // ID seen by VM acknowledge reads.
   output logic vmIrq, // Virtual IRQ request.
   output logic vmFastIrq, // Virtual fast interrupt request.
   output logic [2:0] g1SplitPoint, // Split point used for group 1.
   output logic [2:0] g0SplitPoint, // Split point used for group 0.
   output logic dropDeactivates // Completion write also deactivates.
);
   logic [31:0] vmcr_q;
   logic [31:0] vmcr_d;
   logic [7:0] misr;
   logic [31:0] typeReg;
   logic anyPending;
   logic [$clog2(NUM_ENTRIES+1)-1:0] validCount;
   logic resetSeen_q;

   // Elaboration-time guard: the entry index and the type fields only cover these ranges.
   if (NUM_ENTRIES < 1 || NUM_ENTRIES > 16 || PRI_BITS < 5 || PRI_BITS > 8 ||
       PRE_BITS < 5 || PRE_BITS > PRI_BITS) begin : g_bad_params
      $error("vim_status: unsupported parameters");
   end

   // Tests one entry for the pure pending state.
   function automatic logic is_pending(input logic [1:0] st);
      return st == vim_pkg::STATE_PENDING;
   endfunction : is_pending

   // Entry scan; any nonzero state counts as a valid entry for underflow.
   always_comb begin
      anyPending = 1'b0;
      validCount = '0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         if (is_pending(entryState[2*i +: 2])) begin
            anyPending = 1'b1;
         end
         if (entryState[2*i +: 2] != 2'h0) begin
            validCount = validCount + 1'b1;
         end
      end
   end

   // Flags are recomputed from live inputs; they hold no state to lose.
   always_comb begin
      misr = vim_pkg::MISR_RESET;
      if (resetSeen_q) begin
         misr[7] = hyp.g1OffIrqOn & ~vmcr_q[vim_pkg::G1_BIT];
         misr[6] = hyp.g1OnIrqOn & vmcr_q[vim_pkg::G1_BIT];
         misr[5] = hyp.g0OffIrqOn & ~vmcr_q[vim_pkg::G0_BIT];
         misr[4] = hyp.g0OnIrqOn & vmcr_q[vim_pkg::G0_BIT];
         misr[3] = hyp.noPendingIrqOn & ~anyPending;
         misr[2] = hyp.missingSlotIrqOn & (outstandingCompletionCount != 5'h00);
         misr[1] = hyp.sparseIrqOn & (validCount <= 1);
         misr[0] = |completionStatus;
      end
   end

   assign statusFlags = misr;
   assign maintIrq = (|misr) & hyp.globalOn;

   // Resets mark flags invalid until one cycle after release, so they read zero at reset.
   always_ff @(posedge clock) begin
      resetSeen_q <= rst_n;
   end

   // Type register is a constant built from parameters.
   always_comb begin
      typeReg = 32'h00000000;
      typeReg[31:29] = 3'(PRI_BITS - 1);
      typeReg[28:26] = 3'(PRE_BITS - 1);
      typeReg[4:0] = 5'(NUM_ENTRIES - 1);
   end

   // VM alias writes win over hypervisor writes, keeping the VM's latest view.
   always_comb begin
      vmcr_d = vmcr_q;
      if (regWr && regAddr == vim_pkg::OFF_VMCR) begin
         vmcr_d = regWdata & vim_pkg::VMCR_RW_MASK;
      end
      if (vmWr.pmrWr) begin
         vmcr_d[31:24] = vmWr.data[7:0];
      end
      if (vmWr.bprWr) begin
         vmcr_d[23:21] = vmWr.data[2:0];
      end
      if (vmWr.abprWr) begin
         vmcr_d[20:18] = vmWr.data[2:0];
      end
      if (vmWr.ctlWr) begin
         vmcr_d[9] = vmWr.data[9];
         vmcr_d[4:0] = vmWr.data[4:0];
      end
   end

   // Control view register.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vmcr_q <= vim_pkg::VMCR_RESET;
      end else begin
         vmcr_q <= vmcr_d;
      end
   end

   // Registered read; unmapped offsets read zero and status writes have no effect.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            vim_pkg::OFF_TYPE: regRdata <= typeReg;
            vim_pkg::OFF_VMCR: regRdata <= vmcr_q;
            vim_pkg::OFF_MISR: regRdata <= {24'h000000, misr};
            default: regRdata <= 32'h00000000;
         endcase
      end
   end

   // Split point selection for preemption grouping.
   assign g0SplitPoint = vmcr_q[23:21];
   assign g1SplitPoint = vmcr_q[vim_pkg::SHARED_BIT] ? vmcr_q[23:21] : vmcr_q[20:18];
   assign dropDeactivates = ~vmcr_q[vim_pkg::DROP_BIT];

   // Lower priority value means higher priority, so it must be below the mask.
   logic signalOk;
   assign signalOk = topValid && (topPriority < vmcr_q[31:24]) && hyp.globalOn &&
      (topIsG1 ? vmcr_q[vim_pkg::G1_BIT] : vmcr_q[vim_pkg::G0_BIT]);

   // Output routing, registered.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vmIrq <= 1'b0;
         vmFastIrq <= 1'b0;
         vmAckId <= 10'h000;
      end else begin
         vmIrq <= signalOk & (topIsG1 | ~vmcr_q[vim_pkg::FAST_IRQ_BIT]);
         vmFastIrq <= signalOk & ~topIsG1 & vmcr_q[vim_pkg::FAST_IRQ_BIT];
         vmAckId <= (topIsG1 && !vmcr_q[vim_pkg::ACK_BIT]) ? vim_pkg::ID_G1_HIDDEN : topId;
      end
   end

   // Flag and output checks; flags 7 to 4 and 2 are compared against their own enable terms, flag 0 against the completion bits.
   a_irq_needs_en: assert property (@(posedge clock) disable iff (!rst_n)
      maintIrq |-> hyp.globalOn && misr != 8'h00) else $error("maint irq bad");
   a_g1off_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[7] == (hyp.g1OffIrqOn && !vmcr_q[1])) else $error("bit7");
   a_g1on_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[6] == (hyp.g1OnIrqOn && vmcr_q[1])) else $error("bit6");
   a_g0off_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[5] == (hyp.g0OffIrqOn && !vmcr_q[0])) else $error("bit5");
   a_g0on_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[4] == (hyp.g0OnIrqOn && vmcr_q[0])) else $error("bit4");
   a_missing_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[2] == (hyp.missingSlotIrqOn && outstandingCompletionCount != 0))
      else $error("bit2");
   a_done_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q |-> misr[0] == (completionStatus != 0)) else $error("bit0");
   a_pmr_alias: assert property (@(posedge clock) disable iff (!rst_n)
      vmWr.pmrWr |=> vmcr_q[31:24] == $past(vmWr.data[7:0])) else $error("pmr alias");
   a_g1_split: assert property (@(posedge clock) disable iff (!rst_n)
      !vmcr_q[4] |-> g1SplitPoint == vmcr_q[20:18]) else $error("g1 split");
   a_ack_hide: assert property (@(posedge clock) disable iff (!rst_n)
      topIsG1 && !vmcr_q[2] |=> vmAckId == 10'h3fe) else $error("ack id");

   // Named steps of the register and alias paths used by the checks below.
   sequence s_status_read;
      regRd && regAddr == vim_pkg::OFF_MISR;
   endsequence : s_status_read
   sequence s_type_read;
      regRd && regAddr == vim_pkg::OFF_TYPE;
   endsequence : s_type_read
   sequence s_status_write;
      regWr && regAddr != vim_pkg::OFF_VMCR && !vmWr.pmrWr && !vmWr.bprWr && !vmWr.abprWr &&
      !vmWr.ctlWr;
   endsequence : s_status_write
   sequence s_ctl_write;
      vmWr.ctlWr;
   endsequence : s_ctl_write
   sequence s_split_write;
      vmWr.bprWr;
   endsequence : s_split_write
   sequence s_alias_split_write;
      vmWr.abprWr;
   endsequence : s_alias_split_write

   // An empty list has nothing pending, so the flag must rise.
   a_np_empty: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q && hyp.noPendingIrqOn && entryState == '0 |-> misr[3])
      else $error("no-pending flag low with an empty list");
   // A pending entry 0 must keep the no-pending flag low.
   a_np_pending: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q && hyp.noPendingIrqOn && entryState[1:0] == 2'h1 |-> !misr[3])
      else $error("no-pending flag set with entry 0 pending");
   // Active-and-pending entries are not pending, so the flag still rises.
   a_np_both: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q && hyp.noPendingIrqOn && entryState == {NUM_ENTRIES{2'h3}} |-> misr[3])
      else $error("active-and-pending counted as pending");
   // An empty list is the deepest underflow.
   a_sparse_empty: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q && hyp.sparseIrqOn && entryState == '0 |-> misr[1])
      else $error("underflow flag low with no valid entry");
   // Two valid entries are no underflow.
   a_sparse_two: assert property (@(posedge clock) disable iff (!rst_n)
      resetSeen_q && entryState[1:0] != 2'h0 && entryState[2*NUM_ENTRIES-1 -: 2] != 2'h0 &&
      NUM_ENTRIES > 1 |-> !misr[1])
      else $error("underflow flag set with two valid entries");
   // The first cycle after reset shows no flag and no maintenance request.
   a_reset_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !resetSeen_q |-> misr == 8'h00 && !maintIrq)
      else $error("flags set right after reset");
   // The global enable gates the maintenance output.
   a_global_gate: assert property (@(posedge clock) disable iff (!rst_n)
      !hyp.globalOn |-> !maintIrq) else $error("maintenance request while disabled");
   // A status read returns the live flags one cycle later.
   a_status_read: assert property (@(posedge clock) disable iff (!rst_n)
      s_status_read |=> regRdata == {24'h000000, $past(misr)})
      else $error("status read data wrong");
   // Writes anywhere but the control view leave it untouched.
   a_status_write: assert property (@(posedge clock) disable iff (!rst_n)
      s_status_write |=> vmcr_q == $past(vmcr_q))
      else $error("read-only write changed the control view");
   // A type read reports entries minus one and the priority bits.
   a_type_read: assert property (@(posedge clock) disable iff (!rst_n)
      s_type_read |=> regRdata[4:0] == 5'(NUM_ENTRIES - 1) &&
      regRdata[31:29] == 3'(PRI_BITS - 1))
      else $error("type read data wrong");
   // Alias writes from the virtual machine land in their fields.
   a_ctl_alias: assert property (@(posedge clock) disable iff (!rst_n)
      s_ctl_write |=> vmcr_q[4:0] == $past(vmWr.data[4:0]) &&
      vmcr_q[vim_pkg::DROP_BIT] == $past(vmWr.data[9]))
      else $error("control alias not updated");
   a_bpr_alias: assert property (@(posedge clock) disable iff (!rst_n)
      s_split_write |=> vmcr_q[23:21] == $past(vmWr.data[2:0]))
      else $error("group 0 split alias not updated");
   a_abpr_alias: assert property (@(posedge clock) disable iff (!rst_n)
      s_alias_split_write |=> vmcr_q[20:18] == $past(vmWr.data[2:0]))
      else $error("group 1 split alias not updated");
   // With the shared bit set, group 1 uses the group 0 split point.
   a_shared_split: assert property (@(posedge clock) disable iff (!rst_n)
      vmcr_q[vim_pkg::SHARED_BIT] |-> g1SplitPoint == g0SplitPoint)
      else $error("shared split point not used");
   a_drop_mode: assert property (@(posedge clock) disable iff (!rst_n)
      dropDeactivates != vmcr_q[vim_pkg::DROP_BIT]) else $error("drop mode wrong");
   // Group 0 goes to exactly one request line, picked by the fast bit.
   a_one_line: assert property (@(posedge clock) disable iff (!rst_n)
      !(vmIrq && vmFastIrq)) else $error("both request lines high");
   a_fast_route: assert property (@(posedge clock) disable iff (!rst_n)
      vmFastIrq |-> !$past(topIsG1) && $past(vmcr_q[vim_pkg::FAST_IRQ_BIT]))
      else $error("fast request without group 0 fast routing");
   a_irq_route: assert property (@(posedge clock) disable iff (!rst_n)
      vmIrq && !$past(topIsG1) |-> !$past(vmcr_q[vim_pkg::FAST_IRQ_BIT]))
      else $error("group 0 on normal line while fast routing set");
   // A request needs a priority above the mask and its group enabled.
   a_mask_gate: assert property (@(posedge clock) disable iff (!rst_n)
      vmIrq || vmFastIrq |-> $past(topPriority) < $past(vmcr_q[31:24]))
      else $error("request at or below the mask");
   a_group_gate: assert property (@(posedge clock) disable iff (!rst_n)
      vmIrq || vmFastIrq |-> ($past(topIsG1) ? $past(vmcr_q[1]) : $past(vmcr_q[0])))
      else $error("request for a disabled group");
   // With the acknowledge bit set, group 1 shows its real ID.
   a_ack_show: assert property (@(posedge clock) disable iff (!rst_n)
      topIsG1 && vmcr_q[vim_pkg::ACK_BIT] |=> vmAckId == $past(topId))
      else $error("real ID hidden");
endmodule : vim_status

/* File: rtl/vim_pkg.sv */
// Package with register map, field positions and carrier types of the maintenance status block.
package vim_pkg;
   localparam logic [7:0] OFF_TYPE = 8'h04;
   localparam logic [7:0] OFF_VMCR = 8'h08;
   localparam logic [7:0] OFF_MISR = 8'h10;
   localparam int PMR_LO = 24;
   localparam int BP0_LO = 21;
   localparam int BP1_LO = 18;
   localparam int DROP_BIT = 9;
   localparam int SHARED_BIT = 4;
   localparam int FAST_IRQ_BIT = 3;
   localparam int ACK_BIT = 2;
   localparam int G1_BIT = 1;
   localparam int G0_BIT = 0;
   localparam int TYPE_PRI_LO = 29;
   localparam int TYPE_PRE_LO = 26;
   localparam logic [1:0] STATE_PENDING = 2'h1;
   localparam logic [9:0] ID_G1_HIDDEN = 10'h3fe;
   localparam logic [31:0] VMCR_RW_MASK = 32'hfffc021f;
   localparam logic [31:0] VMCR_RESET = 32'h00000000;
   localparam logic [7:0] MISR_RESET = 8'h00;

   // Hypervisor enable bits feeding the status flags, and the global enable gating the request outputs.
   typedef struct packed {
      logic g1OffIrqOn;
      logic g1OnIrqOn;
      logic g0OffIrqOn;
      logic g0OnIrqOn;
      logic noPendingIrqOn;
      logic missingSlotIrqOn;
      logic sparseIrqOn;
      logic globalOn;
   } vim_hyp_t;

   // Virtual machine write of one alias field.
   typedef struct packed {
      logic pmrWr;
      logic bprWr;
      logic abprWr;
      logic ctlWr;
      logic [31:0] data;
   } vim_vmwr_t;
endpackage : vim_pkg

/* File: verif/vim_host.sv */
// Hypervisor register master model for the maintenance status block.
`timescale 1ns/1ps
module vim_host (
   input wire logic clock, // System clock.
   output logic regWr, // Write strobe.
   output logic regRd, // Read strobe.
   output logic [7:0] regAddr, // Byte offset.
   output logic [31:0] regWdata, // Write data.
   input wire logic [31:0] regRdata // Read data.
);
   // Idle bus at time zero.
   initial begin
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
   end
   // One write; released data turns to its inverse so stale values are never trusted.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clock);
      regWr <= 1'b0;
      regWdata <= ~v;
   endtask : wr
   // One read; the answer is taken one cycle after the strobe edge.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      @(posedge clock);
      #1 v = regRdata;
   endtask : rd
endmodule : vim_host

/* File: verif/vim_status_tb.sv */
// Self-checking testbench of the maintenance status block.
`timescale 1ns/1ps
module vim_status_tb;
   typedef struct packed {
      vim_pkg::vim_hyp_t h;
      logic [1:0] c;
      logic [7:0] e;
      logic [4:0] n;
      logic [3:0] s;
      logic [7:0] f;
   } vim_row_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic regWr, regRd, maintIrq, vmIrq, vmFastIrq, dropDeactivates;
   logic [7:0] regAddr, statusFlags;
   logic [31:0] regWdata, regRdata, d;
   vim_pkg::vim_hyp_t hyp = 8'hff;
   logic [4:0] cnt = 5'h1f;
   logic [7:0] ent = 8'h00;
   logic [3:0] cst = 4'hf;
   vim_pkg::vim_vmwr_t vmWr = '0;
   logic [7:0] topPri = 8'h00;
   logic topIsG1 = 1'b0;
   logic topValid = 1'b0;
   logic [9:0] topId = 10'h123;
   logic [9:0] vmAckId;
   logic [2:0] g1SplitPoint, g0SplitPoint;
   int nMismatch = 0;
   int totalChecks = 0;
   // Enables, control, entries, count, completion bits and the flags they give.
   vim_row_t rows [5] = '{{8'hff, 2'h0, 8'h00, 5'h00, 4'h0, 8'haa},
      {8'hff, 2'h3, 8'h31, 5'h01, 4'h8, 8'h55}, {8'hfe, 2'h1, 8'hff, 5'h1f, 4'h0, 8'h9c},
      {8'h01, 2'h2, 8'h04, 5'h00, 4'h1, 8'h01}, {8'h02, 2'h0, 8'h08, 5'h00, 4'h0, 8'h02}};

   vim_host host (.clock, .regWr, .regRd, .regAddr, .regWdata, .regRdata);
   vim_status #(.NUM_ENTRIES(4)) i_dut (.clock, .rst_n, .regWr, .regRd, .regAddr, .regWdata,
      .regRdata, .hyp, .outstandingCompletionCount(cnt), .entryState(ent),
      .completionStatus(cst), .vmWr, .topPriority(topPri), .topIsG1, .topId, .topValid,
      .maintIrq, .statusFlags, .vmAckId, .vmIrq, .vmFastIrq, .g1SplitPoint, .g0SplitPoint,
      .dropDeactivates);

   // Free-running clock at 100 MHz.
   initial begin
      forever #5 clock = ~clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One-cycle alias-field write from the virtual machine side.
   task automatic vm(input logic [3:0] k, input logic [31:0] v);
      @(posedge clock);
      vmWr <= {k, v};
      @(posedge clock);
      vmWr <= '0;
   endtask : vm

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   // The whole run needs about a hundred cycles, so this limit only catches a hang.
   initial begin
      repeat (3000) @(posedge clock);
      nMismatch++;
      summarize;
   end

   // Main sequence: reset, table of flag cases, then register and alias cases.
   initial begin
      repeat (7) @(posedge clock);
      #1 chk(statusFlags, 32'h0);
      @(posedge clock);
      rst_n <= 1'b1;
      host.rd(vim_pkg::OFF_VMCR, d);
      chk(d, vim_pkg::VMCR_RESET);
      foreach (rows[i]) begin
         host.wr(vim_pkg::OFF_VMCR, {30'h0, rows[i].c});
         hyp <= rows[i].h;
         ent <= rows[i].e;
         cnt <= rows[i].n;
         cst <= rows[i].s;
         @(posedge clock);
         #1 chk(statusFlags, rows[i].f);
         chk(maintIrq, (rows[i].f != 0) & rows[i].h.globalOn);
         host.rd(vim_pkg::OFF_MISR, d);
         chk(d, rows[i].f);
      end
      host.wr(vim_pkg::OFF_VMCR, '1);
      host.rd(vim_pkg::OFF_VMCR, d);
      chk(d, vim_pkg::VMCR_RW_MASK);
      host.wr(vim_pkg::OFF_VMCR, 32'h00a80210);
      #1 chk(g1SplitPoint, 3'h5);
      chk(dropDeactivates, 1'b0);
      host.wr(vim_pkg::OFF_VMCR, 32'h00a80000);
      #1 chk(g1SplitPoint, 3'h2);
      chk(g0SplitPoint, 3'h5);
      chk(dropDeactivates, 1'b1);
      host.wr(vim_pkg::OFF_MISR, '1);
      host.wr(vim_pkg::OFF_TYPE, '0);
      host.rd(vim_pkg::OFF_VMCR, d);
      chk(d, 32'h00a80000);
      host.rd(vim_pkg::OFF_TYPE, d);
      chk(d, 32'h90000003);
      host.rd(8'h0c, d);
      chk(d, 32'h0);
      hyp <= 8'h01;
      vm(4'h8, 32'h40);
      vm(4'h1, 32'h2);
      topValid <= 1'b1;
      topIsG1 <= 1'b1;
      topPri <= 8'h10;
      repeat (2) @(posedge clock);
      #1 chk(vmAckId, vim_pkg::ID_G1_HIDDEN);
      chk(vmIrq, 1'b1);
      @(posedge clock);
      topPri <= 8'h40;
      repeat (2) @(posedge clock);
      #1 chk(vmIrq, 1'b0);
      vm(4'h4, 32'h3);
      vm(4'h2, 32'h6);
      vm(4'h1, 32'hd);
      repeat (2) @(posedge clock);
      #1 chk(vmAckId, topId);
      @(posedge clock);
      topIsG1 <= 1'b0;
      topPri <= 8'h10;
      repeat (2) @(posedge clock);
      #1 chk(vmFastIrq, 1'b1);
      chk(vmIrq, 1'b0);
      host.rd(vim_pkg::OFF_VMCR, d);
      chk(d, 32'h4078000d);
      vm(4'h1, 32'h4);
      repeat (2) @(posedge clock);
      #1 chk({vmIrq, vmFastIrq}, 32'h0);
      vm(4'h1, 32'h1);
      repeat (2) @(posedge clock);
      #1 chk({vmIrq, vmFastIrq}, 32'h2);
      // Second reset in mid-run with flag sources active.
      @(posedge clock);
      cst <= 4'hf;
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk(statusFlags, 32'h0);
      chk({vmIrq, vmFastIrq}, 32'h0);
      @(posedge clock);
      rst_n <= 1'b1;
      host.rd(vim_pkg::OFF_VMCR, d);
      chk(d, vim_pkg::VMCR_RESET);
      @(posedge clock);
      #1 chk(statusFlags, 32'h01);
      chk(maintIrq, 1'b1);
      summarize;
   end
endmodule : vim_status_tb
